// ==== design/fiber_ability_cfg.svh ====
`ifndef FIBER_ABILITY_CFG_SVH
`define FIBER_ABILITY_CFG_SVH

// ********************************************************************
// Register indices (byte address is four times the index)
// ********************************************************************
`define IDX_LOCAL_ADVERT 8'h04
`define IDX_PARTNER_ABILITY 8'h05
`define IDX_CTRL 8'h10
`define IDX_STATUS 8'h11

// ********************************************************************
// Reset and constant values
// ********************************************************************
`define MEDIA_ADVERT_VALUE 16'h0001
`define PARTNER_RESET 16'h0000
`define MODE_RESET 2'b01
`define UNMAPPED_READ 16'h0000

// ********************************************************************
// Received code word field positions
// ********************************************************************
`define BIT_NEXT_PAGE 15
`define BIT_COPPER_LINK 15
`define BIT_ACK 14
`define FLD_RFAULT_HI 13
`define FLD_RFAULT_LO 12
`define BIT_DUPLEX 12
`define FLD_SPEED_HI 11
`define FLD_SPEED_LO 10
`define BIT_TX_PAUSE 9
`define BIT_RX_PAUSE 8
`define FLD_PAUSE_HI 8
`define FLD_PAUSE_LO 7
`define BIT_FIBER_MEDIA 7
`define BIT_HALF_DUPLEX 6
`define BIT_FULL_DUPLEX 5

// ********************************************************************
// Control and status field positions
// ********************************************************************
`define CTRL_MODE_HI 1
`define CTRL_MODE_LO 0
`define CTRL_SOFT_RESET 2
`define STAT_LINK 0
`define STAT_PAGE_RCVD 1
`define STAT_CNT_LO 8

// ********************************************************************
// Bus constants
// ********************************************************************
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

// ==== design/fiber_ability_pkg.sv ====
package fiber_ability_pkg;

	// Interface mode selection for the partner word layout
	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_BASEX = 2'b01,
		MODE_SGMII_SYS = 2'b10,
		MODE_SGMII_MEDIA = 2'b11
	} if_mode_type;

	// Bus data phase tracker, one-hot
	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_READ = 3'b010,
		PH_WRITE = 3'b100
	} phase_type;

endpackage

// ==== design/partner_layout_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface partner_layout_if;
	import fiber_ability_pkg::*;

	logic [15:0] raw_word;
	if_mode_type mode;
	logic [15:0] layout_word;

	modport src (output raw_word, output mode, input layout_word);
	modport map (input raw_word, input mode, output layout_word);
endinterface

`default_nettype wire

// ==== design/partner_word_layout.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fiber_ability_cfg.svh"

module partner_word_layout (
	// Raw word and mode in, visible layout out
	partner_layout_if.map lay
);
	import fiber_ability_pkg::*;

	// ****************************************************************
	// Layout selection
	// ****************************************************************
	function automatic logic [15:0] shape(input logic [15:0] w,
		input if_mode_type m);
		logic [15:0] r;
		r = 16'h0000;
		case (m)
			MODE_BASEX: begin
				r[`BIT_NEXT_PAGE] = w[`BIT_NEXT_PAGE];
				r[`BIT_ACK] = w[`BIT_ACK];
				r[`FLD_RFAULT_HI:`FLD_RFAULT_LO] =
					w[`FLD_RFAULT_HI:`FLD_RFAULT_LO];
				r[`FLD_PAUSE_HI:`FLD_PAUSE_LO] =
					w[`FLD_PAUSE_HI:`FLD_PAUSE_LO];
				r[`BIT_HALF_DUPLEX] = w[`BIT_HALF_DUPLEX];
				r[`BIT_FULL_DUPLEX] = w[`BIT_FULL_DUPLEX];
			end
			MODE_SGMII_SYS: begin
				// Everything but the acknowledge stays zero
				r[`BIT_ACK] = w[`BIT_ACK];
			end
			MODE_SGMII_MEDIA: begin
				r[`BIT_COPPER_LINK] = w[`BIT_COPPER_LINK];
				r[`BIT_ACK] = w[`BIT_ACK];
				r[`BIT_DUPLEX] = w[`BIT_DUPLEX];
				r[`FLD_SPEED_HI:`FLD_SPEED_LO] =
					w[`FLD_SPEED_HI:`FLD_SPEED_LO];
				r[`BIT_TX_PAUSE] = w[`BIT_TX_PAUSE];
				r[`BIT_RX_PAUSE] = w[`BIT_RX_PAUSE];
				r[`BIT_FIBER_MEDIA] = w[`BIT_FIBER_MEDIA];
			end
			default: begin
				// Mode 00 has no partner layout; reads zero
				r = 16'h0000;
			end
		endcase
		return r;
	endfunction

	assign lay.layout_word = shape(lay.raw_word, lay.mode);

endmodule // partner_word_layout

`default_nettype wire

// ==== design/fiber_partner_ability_capture.sv ====
// Operation
// - Link drop clears all captured fields; each base page reloads them.
// - 1000BASE-X layout keeps received bit 15 as partner next-page ability.
// - 1000BASE-X and SGMII media layouts keep received bit 14, acknowledge.
// - 1000BASE-X layout keeps received bits 13:12 as remote fault code.
// - 1000BASE-X layout keeps received bits 8:7 as partner pause ability.
// - 1000BASE-X layout keeps received bit 6, partner half duplex.
// - 1000BASE-X layout keeps bit 5, full duplex; 11:9, 4:0 read zero.
// - SGMII system layout keeps only bit 14; all other bits zero.
// - SGMII media layout keeps bit 15, partner copper link up.
// - SGMII media layout keeps bit 12 as partner duplex; bit 13 zero.
// - SGMII media layout keeps bits 11:10 as partner speed code.
// - SGMII media bits 9, 8, 7 from word; bits 6:0 zero.
// - In SGMII media mode the local advertisement reads constant 0x0001.
// - Two-bit mode 01, 10, 11 picks BASE-X, system, media layout.
`timescale 1ns/1ps
`default_nettype none
`include "fiber_ability_cfg.svh"

module fiber_partner_ability_capture #(
	parameter int CNT_W = 8
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Link partner side
	input wire logic link_up,
	input wire logic page_valid,
	input wire logic [15:0] page_word,
	// Mode seen by the rest of the port
	output fiber_ability_pkg::if_mode_type if_mode
);
	import fiber_ability_pkg::*;

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	// Page counter shares status bits 15:8
	generate
		if (CNT_W < 1 || CNT_W > 8) begin : g_bad_cnt
			$error("CNT_W must lie between 1 and 8");
		end
	endgenerate

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [7:0] word_index(input logic [31:0] a);
		return a[9:2];
	endfunction

	// ****************************************************************
	// Write permission
	// ****************************************************************
	// Only the control word accepts data; both ability words and the
	// status word are read-only, so a write there must change nothing
	function automatic logic writable(input logic [7:0] i);
		logic ok;
		ok = 1'b0;
		case (i)
			`IDX_LOCAL_ADVERT: begin
				ok = 1'b0;
			end
			`IDX_PARTNER_ABILITY: begin
				ok = 1'b0;
			end
			`IDX_CTRL: begin
				ok = 1'b1;
			end
			`IDX_STATUS: begin
				ok = 1'b0;
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction

	function automatic logic is_mapped(input logic [31:0] a);
		logic [7:0] i;
		i = word_index(a);
		return (a[31:10] == 22'h000000) &&
			(i == `IDX_LOCAL_ADVERT || i == `IDX_PARTNER_ABILITY ||
			i == `IDX_CTRL || i == `IDX_STATUS);
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic addr_take;
	logic rd_take;
	logic wr_take;
	phase_type phase_q;
	logic [7:0] wr_idx_q;
	logic wr_mapped_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	if_mode_type mode_q;
	logic soft_clear_q;
	logic link_q;
	logic link_drop;
	logic page_take;
	logic [15:0] raw_q;
	logic page_rcvd_q;
	logic stat_read;
	logic [CNT_W-1:0] page_cnt_q;
	logic [15:0] status_word;
	logic [15:0] ctrl_word;
	logic [15:0] advert_word;
	logic ctrl_write;

	partner_layout_if lay ();

	// ****************************************************************
	// Bus address phase
	// ****************************************************************
	// Zero wait states: every phase ends in the cycle it starts
	assign hreadyout = 1'b1;
	assign hresp = `HRESP_OKAY;
	assign hrdata = rdata_q;

	assign addr_take = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
	assign rd_take = addr_take && !hwrite;
	assign wr_take = addr_take && hwrite;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q <= PH_IDLE;
		end else if (hready) begin
			if (rd_take) begin
				phase_q <= PH_READ;
			end else if (wr_take) begin
				phase_q <= PH_WRITE;
			end else begin
				phase_q <= PH_IDLE;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_idx_q <= 8'h00;
			wr_mapped_q <= 1'b0;
		end else if (wr_take) begin
			wr_idx_q <= word_index(haddr);
			wr_mapped_q <= is_mapped(haddr);
		end
	end

	// ****************************************************************
	// Write data phase
	// ****************************************************************
	// Only the control word takes writes; both ability words are
	// read-only and a write there leaves them untouched
	always_comb begin
		ctrl_write = 1'b0;
		case (phase_q)
			PH_WRITE: begin
				ctrl_write = wr_mapped_q && writable(wr_idx_q);
			end
			PH_IDLE, PH_READ: begin
				ctrl_write = 1'b0;
			end
			default: begin
				ctrl_write = 1'b0;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= if_mode_type'(`MODE_RESET);
		end else if (ctrl_write) begin
			mode_q <= if_mode_type'(hwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
		end
	end

	// Soft reset bit self-clears; it is a one-cycle pulse only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			soft_clear_q <= 1'b0;
		end else begin
			soft_clear_q <= ctrl_write && hwdata[`CTRL_SOFT_RESET];
		end
	end

	assign if_mode = mode_q;

	// ****************************************************************
	// Link state
	// ****************************************************************
	// Only the falling edge clears; pages arrive before link is up
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link_q <= 1'b0;
		end else begin
			link_q <= link_up;
		end
	end

	assign link_drop = link_q && !link_up;
	assign page_take = page_valid;

	// ****************************************************************
	// Captured base page
	// ****************************************************************
	// Raw word is kept whole; the layout is applied per mode when
	// read, so a mode change never needs a new page
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_q <= `PARTNER_RESET;
		end else if (page_take) begin
			raw_q <= page_word;
		end else if (link_drop || soft_clear_q) begin
			raw_q <= `PARTNER_RESET;
		end
	end

	assign lay.raw_word = raw_q;
	assign lay.mode = mode_q;

	partner_word_layout u_layout (
		.lay(lay.map)
	);

	// ****************************************************************
	// Page status
	// ****************************************************************
	// Latched high until status is read; a new page wins the clear
	assign stat_read = rd_take && is_mapped(haddr) &&
		(word_index(haddr) == `IDX_STATUS);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			page_rcvd_q <= 1'b0;
		end else if (page_take) begin
			page_rcvd_q <= 1'b1;
		end else if (stat_read || soft_clear_q) begin
			page_rcvd_q <= 1'b0;
		end
	end

	// Saturates at all ones rather than wraps so software sees a ceiling
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			page_cnt_q <= '0;
		end else if (soft_clear_q) begin
			page_cnt_q <= '0;
		end else if (page_take && !(&page_cnt_q)) begin
			page_cnt_q <= page_cnt_q + 1'b1;
		end
	end

	always_comb begin
		status_word = 16'h0000;
		status_word[`STAT_LINK] = link_q;
		status_word[`STAT_PAGE_RCVD] = page_rcvd_q;
		status_word[`STAT_CNT_LO +: CNT_W] = page_cnt_q;
	end

	always_comb begin
		ctrl_word = 16'h0000;
		ctrl_word[`CTRL_MODE_HI:`CTRL_MODE_LO] = mode_q;
	end

	// Advertisement content lives elsewhere outside media mode
	always_comb begin
		case (mode_q)
			MODE_SGMII_MEDIA: begin
				advert_word = `MEDIA_ADVERT_VALUE;
			end
			MODE_OFF, MODE_BASEX, MODE_SGMII_SYS: begin
				advert_word = `UNMAPPED_READ;
			end
			default: begin
				advert_word = `UNMAPPED_READ;
			end
		endcase
	end

	// ****************************************************************
	// Read data
	// ****************************************************************
	// Sampled at the address phase so hrdata comes from a flop
	always_comb begin
		rdata_d = 32'h00000000;
		if (is_mapped(haddr)) begin
			case (word_index(haddr))
				`IDX_LOCAL_ADVERT: begin
					rdata_d = {16'h0000, advert_word};
				end
				`IDX_PARTNER_ABILITY: begin
					rdata_d = {16'h0000, lay.layout_word};
				end
				`IDX_CTRL: begin
					rdata_d = {16'h0000, ctrl_word};
				end
				`IDX_STATUS: begin
					rdata_d = {16'h0000, status_word};
				end
				default: begin
					rdata_d = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h00000000;
		end else if (rd_take) begin
			rdata_q <= rdata_d;
		end
	end

	// ****************************************************************
	// Write ignore on ability words
	// ****************************************************************
	// No path exists from hwdata to raw_q; writes to index 4 or 5
	// complete with OKAY and change nothing

endmodule // fiber_partner_ability_capture

`default_nettype wire

// ==== test/ability_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fiber_ability_cfg.svh"

module ability_checker #(
	parameter int CNT_W = 8
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Link side
	input wire logic link_up,
	input wire logic page_valid,
	input wire logic [15:0] page_word,
	input wire fiber_ability_pkg::if_mode_type if_mode
);
	import fiber_ability_pkg::*;
	logic take, rd_par, rd_adv, wr_ctl;

	// ****
	// Address phase decode
	// ****
	assign take = hsel & hready & htrans[1];
	assign rd_par = take & ~hwrite & (haddr[9:2] == `IDX_PARTNER_ABILITY);
	assign rd_adv = take & ~hwrite & (haddr[9:2] == `IDX_LOCAL_ADVERT);
	assign wr_ctl = take & hwrite & (haddr[9:2] == `IDX_CTRL);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ****
	// Properties
	// ****
	a_advert_media_const: assert property (rd_adv && if_mode == MODE_SGMII_MEDIA
		|=> hrdata == 32'h0000_0001) else $error("advert not constant");
	a_basex_capture: assert property (rd_par && if_mode == MODE_BASEX
		&& $past(page_valid) |=> hrdata == {16'h0, $past(page_word, 2) & 16'hf1e0})
		else $error("basex layout wrong");
	a_sys_capture: assert property (rd_par && if_mode == MODE_SGMII_SYS
		&& $past(page_valid) |=> hrdata == {16'h0, $past(page_word, 2) & 16'h4000})
		else $error("system layout wrong");
	a_media_capture: assert property (rd_par && if_mode == MODE_SGMII_MEDIA
		&& $past(page_valid) |=> hrdata == {16'h0, $past(page_word, 2) & 16'hdf80})
		else $error("media layout wrong");
	a_basex_zero_bits: assert property (rd_par && if_mode == MODE_BASEX
		|=> (hrdata & 32'hffff_0e1f) == 32'h0) else $error("basex reserved set");
	a_media_zero_bits: assert property (rd_par && if_mode == MODE_SGMII_MEDIA
		|=> (hrdata & 32'hffff_207f) == 32'h0) else $error("media reserved set");
	a_mode_by_write: assert property (!$stable(if_mode) |-> $past(wr_ctl, 2))
		else $error("mode moved without write");
	a_link_drop_clear: assert property ($fell(link_up) && !page_valid ##1 rd_par
		|=> hrdata[15:0] == 16'h0) else $error("link drop kept fields");
endmodule // ability_checker

bind fiber_partner_ability_capture ability_checker #(.CNT_W(CNT_W)) u_chk (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
	.link_up, .page_valid, .page_word, .if_mode);

`default_nettype wire

// ==== test/link_partner_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module link_partner_model (
	// Clock
	input wire logic hclk,
	// Pages toward the device
	output logic link_up,
	output logic page_valid,
	output logic [15:0] page_word
);
	initial begin
		link_up = 1'b0;
		page_valid = 1'b0;
		page_word = 16'h0;
	end

	task automatic set_link(input logic up);
		link_up <= up;
		@(posedge hclk);
	endtask

	// Two pages back to back; word is inverted once released so stale
	// data cannot pass for a fresh capture
	task automatic send(input logic [15:0] a, input logic [15:0] b,
		input int gap);
		repeat (gap) @(posedge hclk);
		page_valid <= 1'b1;
		page_word <= a;
		@(posedge hclk);
		page_word <= b;
		@(posedge hclk);
		page_valid <= 1'b0;
		page_word <= ~b;
	endtask
endmodule // link_partner_model

`default_nettype wire

// ==== test/fiber_partner_ability_capture_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fiber_ability_cfg.svh"

module fiber_partner_ability_capture_tb_top;
	import fiber_ability_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic link_up, page_valid;
	logic [15:0] page_word;
	if_mode_type if_mode;
	int fails, total_checks, cyc;
	logic [15:0] words [3] = '{16'hffff, 16'h5a5a, 16'ha5a5};

	assign hready = hreadyout;
	fiber_partner_ability_capture #(.CNT_W(8)) DUT (.hclk, .hresetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hresp, .hrdata, .link_up, .page_valid, .page_word,
		.if_mode);
	link_partner_model lp (.hclk, .link_up, .page_valid, .page_word);

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// ****
	// Bus and check tasks
	// ****
	task automatic bus(input logic w, input logic [7:0] i,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {22'h0, i, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	function automatic logic [15:0] lay(input int m, input logic [15:0] x);
		case (m)
			1: return x & 16'hf1e0;
			2: return x & 16'h4000;
			3: return x & 16'hdf80;
			default: return 16'h0;
		endcase
	endfunction

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard, far above the hundred or so cycles the tests need
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			end_sim();
		end
	end

	// ****
	// Tests
	// ****
	initial begin
		{hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, `IDX_PARTNER_ABILITY, 0, rd); chk(rd, 32'h0);
		bus(0, `IDX_CTRL, 0, rd); chk(rd, 32'h1);
		chk({30'h0, if_mode}, 32'h1);
		$display("reset test done");
		lp.set_link(1'b1);
		for (int i = 0; i < 3; i++) begin
			for (int m = 1; m < 4; m++) begin
				bus(1, `IDX_CTRL, 32'(m), rd);
				lp.send(~words[i], words[i], m - 1);
				bus(0, `IDX_PARTNER_ABILITY, 0, rd);
				chk(rd, {16'h0, lay(m, words[i])});
				chk({30'h0, if_mode}, 32'(m));
			end
		end
		$display("layout test done");
		bus(1, `IDX_LOCAL_ADVERT, 32'h0, rd);
		bus(0, `IDX_LOCAL_ADVERT, 0, rd); chk(rd, 32'h1);
		bus(1, `IDX_CTRL, 32'h1, rd);
		bus(0, `IDX_PARTNER_ABILITY, 0, rd); chk(rd, {16'h0, lay(1, words[2])});
		bus(1, `IDX_PARTNER_ABILITY, 32'hffff_ffff, rd);
		chk({30'h0, hreadyout, hresp}, 32'h2);
		bus(0, `IDX_PARTNER_ABILITY, 0, rd); chk(rd, {16'h0, lay(1, words[2])});
		bus(0, 8'h20, 0, rd); chk(rd, 32'h0);
		$display("mode and write test done");
		lp.set_link(1'b0);
		bus(0, `IDX_PARTNER_ABILITY, 0, rd); chk(rd, 32'h0);
		lp.set_link(1'b1);
		lp.send(16'h0000, 16'hc0a0, 2);
		bus(0, `IDX_PARTNER_ABILITY, 0, rd); chk(rd, 32'hc0a0);
		$display("link drop test done");
		end_sim();
	end
endmodule // fiber_partner_ability_capture_tb_top

`default_nettype wire
